// ### logic/dtc_pkg.sv
// Purpose: shared constants and types for the dual timer/counter
// Assumes: 8-bit register port, 10 MHz system clock, 4-clock machine cycle
// Notes:   register offsets are word indices on a 3-bit address
package dtc_pkg;

  // register offsets
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_CTRL = 3'h1;
  localparam logic [2:0] ADDR_RATE = 3'h2;
  localparam logic [2:0] ADDR_U0LO = 3'h3;
  localparam logic [2:0] ADDR_U0HI = 3'h4;
  localparam logic [2:0] ADDR_U1LO = 3'h5;
  localparam logic [2:0] ADDR_U1HI = 3'h6;

  // mode register fields
  localparam int MODE_U0_LSB   = 0;
  localparam int MODE_U0_FUNC  = 2;
  localparam int MODE_U0_GATE  = 3;
  localparam int MODE_U1_LSB   = 4;
  localparam int MODE_U1_FUNC  = 6;
  localparam int MODE_U1_GATE  = 7;

  // control register fields
  localparam int CTRL_U0_RUN   = 4;
  localparam int CTRL_U0_OVF   = 5;
  localparam int CTRL_U1_RUN   = 6;
  localparam int CTRL_U1_OVF   = 7;

  // rate register fields
  localparam int RATE_U0_FAST  = 0;
  localparam int RATE_U1_FAST  = 1;

  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;

  // machine cycle timing: prescaler runs 0..11, low two bits are the phase
  localparam int         SYS_CLK_NS   = 100;
  localparam int         MCYCLE_CLKS  = 4;
  localparam logic [3:0] PRE_LAST     = 4'hb;
  localparam logic [1:0] PHASE_C3     = 2'h2;
  localparam logic [1:0] PHASE_C4     = 2'h3;
  localparam logic [3:0] TICK12_POS   = 4'h2;
  localparam logic [3:0] TICK6_POS_A  = 4'h2;
  localparam logic [3:0] TICK6_POS_B  = 4'h6;

  typedef enum logic [1:0] {
    MODE_13BIT  = 2'h0,
    MODE_16BIT  = 2'h1,
    MODE_RELOAD = 2'h2,
    MODE_SPLIT  = 2'h3
  } dtc_mode_e;

  typedef struct packed {
    logic unit0CountPin;
    logic unit1CountPin;
    logic unit0GatePin;
    logic unit1GatePin;
  } dtc_pins_s;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic       ovf;
  } dtc_step_s;

endpackage

// ### logic/dtc_pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs are asynchronous to sys_clk
// Notes:   output changes only once stages two and three agree
`timescale 1ns/10ps
module dtc_pin_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic             clkEn,
  // pins
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
    end else if (clkEn) begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // per-bit agreement filter
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          pinOut[i] <= 1'b0;
        end else if (clkEn && (stage2_r[i] == stage3_r[i])) begin
          pinOut[i] <= stage3_r[i];
        end
      end
    end
  endgenerate

endmodule

// ### logic/dtc_dual_timer.sv
// Purpose: two 16-bit timer/counters with four modes each
// Assumes: 4-clock machine cycle, phases C1..C4, one clock enable
// Notes:   register port is 8 bits wide, read data valid one cycle later
//
// Summary of operation
// - two 16-bit units, high and low bytes
// - timer rate one twelfth or one sixth clock
// - reset selects the one-twelfth rate
// - count pins sampled at C4, high-low edge
// - edge counting limited to clock over 8
// - count registers update at phase C3
// - function bit 2 and 6 select edges
// - two-bit mode field per unit
// - count when run and gate condition hold
// - mode 0 is 13 bits, low byte top three ignored
// - mode 0 flags rollover 1fff to 0
// - mode 1 full 16-bit rollover flag
// - mode 2 low byte reloads from high
// - reload leaves high byte untouched
// - unit 1 mode 3 holds its count
// - unit 0 split low uses unit 0 controls
// - split high counts clock/12, unit 1 run bit
// - unit 1 still runs modes 0 to 2
// - overflow flag set at C3 of overflow cycle
// - vector acknowledge clears overflow flag
`timescale 1ns/10ps
module dtc_dual_timer (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic             clkEn,
  // register port
  input  wire logic [2:0]       regAddr,
  input  wire logic [7:0]       regWrData,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic      [7:0]       regRdData,
  // external pins
  input  wire dtc_pkg::dtc_pins_s pinsIn,
  // interrupt controller side
  input  wire logic             unit0VectorAck,
  input  wire logic             unit1VectorAck,
  output logic                  unit0OverflowFlag,
  output logic                  unit1OverflowFlag
);
  import dtc_pkg::*;

  // step one unit in modes 0..2; mode 3 steps the low byte alone
  function automatic dtc_step_s cnt_step(input dtc_mode_e mode,
                                         input logic [7:0] hi,
                                         input logic [7:0] lo);
    dtc_step_s s;
    logic [12:0] v13;
    logic [15:0] v16;
    s   = '{hi: hi, lo: lo, ovf: 1'b0};
    v13 = 13'h0000;
    v16 = 16'h0000;
    case (mode)
      MODE_13BIT: begin
        v13   = {hi, lo[4:0]} + 13'h0001;
        s.hi  = v13[12:5];
        s.lo  = {lo[7:5], v13[4:0]};
        s.ovf = (v13 == 13'h0000);
      end
      MODE_16BIT: begin
        v16   = {hi, lo} + 16'h0001;
        s.hi  = v16[15:8];
        s.lo  = v16[7:0];
        s.ovf = (v16 == 16'h0000);
      end
      MODE_RELOAD: begin
        if (lo == 8'hff) begin
          s.lo  = hi;
          s.ovf = 1'b1;
        end else begin
          s.lo  = lo + 8'h01;
        end
      end
      default: begin
        s.lo  = lo + 8'h01;
        s.ovf = (lo == 8'hff);
      end
    endcase
    return s;
  endfunction

  // register file
  logic [7:0] modeReg_r, rateReg_r;
  logic       unit0Run_r, unit1Run_r;
  logic [7:0] unit0CountLow_r, unit0CountHigh_r;
  logic [7:0] unit1CountLow_r, unit1CountHigh_r;
  logic [7:0] unit0CountLow_nxt, unit0CountHigh_nxt;
  logic [7:0] unit1CountLow_nxt, unit1CountHigh_nxt;

  // machine cycle timing
  logic [3:0] prescale_r;
  logic [1:0] phase;
  logic       atC3, atC4;
  logic       tick12, tick6;

  // pin sampling
  dtc_pins_s  pinsSync;
  logic       unit0Sample_r, unit1Sample_r;
  logic       unit0EdgePend_r, unit1EdgePend_r;

  // decoded controls
  dtc_mode_e  unit0Mode, unit1Mode;
  logic       unit0Func, unit1Func;
  logic       unit0Gate, unit1Gate;
  logic       unit0Fast, unit1Fast;
  logic       unit0Split;
  logic       unit0Enable, unit1Enable;
  logic       unit0Tick, unit1Tick;
  logic       unit0Inc, unit0HiInc, unit1Inc;
  dtc_step_s  unit0Step, unit1Step;
  logic       unit0OvfSet, unit1OvfSet;

  // write decode
  wire        wrMode = regWr && (regAddr == ADDR_MODE);
  wire        wrCtrl = regWr && (regAddr == ADDR_CTRL);
  wire        wrRate = regWr && (regAddr == ADDR_RATE);
  wire        wrU0Lo = regWr && (regAddr == ADDR_U0LO);
  wire        wrU0Hi = regWr && (regAddr == ADDR_U0HI);
  wire        wrU1Lo = regWr && (regAddr == ADDR_U1LO);
  wire        wrU1Hi = regWr && (regAddr == ADDR_U1HI);

  // count and gate pins share one synchroniser
  dtc_pin_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .clkEn   (clkEn),
    .pinIn   (pinsIn),
    .pinOut  (pinsSync)
  );

  // prescaler: three machine cycles of four phases each
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prescale_r <= 4'h0;
    end else if (clkEn) begin
      prescale_r <= (prescale_r == PRE_LAST) ? 4'h0 : prescale_r + 4'h1;
    end
  end

  assign phase  = prescale_r[1:0];
  assign atC3   = (phase == PHASE_C3);
  assign atC4   = (phase == PHASE_C4);
  assign tick12 = (prescale_r == TICK12_POS);
  // both sixth-rate ticks fall at C3, four and eight clocks apart
  assign tick6  = (prescale_r == TICK6_POS_A) || (prescale_r == TICK6_POS_B);

  // mode register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      modeReg_r <= RST_BYTE;
    end else if (clkEn && wrMode) begin
      modeReg_r <= regWrData;
    end
  end

  // rate register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rateReg_r <= RST_BYTE;
    end else if (clkEn && wrRate) begin
      rateReg_r <= regWrData;
    end
  end

  // run bits
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      unit0Run_r <= 1'b0;
      unit1Run_r <= 1'b0;
    end else if (clkEn && wrCtrl) begin
      unit0Run_r <= regWrData[CTRL_U0_RUN];
      unit1Run_r <= regWrData[CTRL_U1_RUN];
    end
  end

  assign unit0Mode = dtc_mode_e'(modeReg_r[MODE_U0_LSB +: 2]);
  assign unit1Mode = dtc_mode_e'(modeReg_r[MODE_U1_LSB +: 2]);
  assign unit0Func = modeReg_r[MODE_U0_FUNC];
  assign unit1Func = modeReg_r[MODE_U1_FUNC];
  assign unit0Gate = modeReg_r[MODE_U0_GATE];
  assign unit1Gate = modeReg_r[MODE_U1_GATE];
  assign unit0Fast = rateReg_r[RATE_U0_FAST];
  assign unit1Fast = rateReg_r[RATE_U1_FAST];
  assign unit0Split = (unit0Mode == MODE_SPLIT);

  // count pin sampling once per machine cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      unit0Sample_r <= 1'b0;
      unit1Sample_r <= 1'b0;
    end else if (clkEn && atC4) begin
      unit0Sample_r <= pinsSync.unit0CountPin;
      unit1Sample_r <= pinsSync.unit1CountPin;
    end
  end

  // edge seen at C4 is applied at the next C3, so two cycles per edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      unit0EdgePend_r <= 1'b0;
      unit1EdgePend_r <= 1'b0;
    end else if (clkEn) begin
      if (atC4) begin
        unit0EdgePend_r <= unit0Sample_r && !pinsSync.unit0CountPin;
        unit1EdgePend_r <= unit1Sample_r && !pinsSync.unit1CountPin;
      end else if (atC3) begin
        unit0EdgePend_r <= 1'b0;
        unit1EdgePend_r <= 1'b0;
      end
    end
  end

  // gating
  always_comb begin
    unit0Enable = unit0Run_r && (!unit0Gate || pinsSync.unit0GatePin);
    // unit 1 loses its run bit to the split high byte
    unit1Enable = (unit0Split || unit1Run_r)
                  && (!unit1Gate || pinsSync.unit1GatePin)
                  && (unit1Mode != MODE_SPLIT);
  end

  // time base selection
  always_comb begin
    if (unit0Func) begin
      unit0Tick = atC3 && unit0EdgePend_r;
    end else if (unit0Split) begin
      unit0Tick = tick12;
    end else begin
      unit0Tick = unit0Fast ? tick6 : tick12;
    end
    if (unit1Func) begin
      unit1Tick = atC3 && unit1EdgePend_r;
    end else begin
      unit1Tick = unit1Fast ? tick6 : tick12;
    end
  end

  assign unit0Inc   = unit0Enable && unit0Tick;
  assign unit0HiInc = unit0Split && unit1Run_r && tick12;
  assign unit1Inc   = unit1Enable && unit1Tick;

  assign unit0Step = cnt_step(unit0Mode, unit0CountHigh_r, unit0CountLow_r);
  assign unit1Step = cnt_step(unit1Mode, unit1CountHigh_r, unit1CountLow_r);

  // unit 0 next count
  always_comb begin
    unit0CountLow_nxt  = unit0CountLow_r;
    unit0CountHigh_nxt = unit0CountHigh_r;
    if (unit0Split) begin
      if (unit0Inc) begin
        unit0CountLow_nxt = unit0Step.lo;
      end
      if (unit0HiInc) begin
        unit0CountHigh_nxt = unit0CountHigh_r + 8'h01;
      end
    end else if (unit0Inc) begin
      unit0CountLow_nxt  = unit0Step.lo;
      unit0CountHigh_nxt = unit0Step.hi;
    end
    if (wrU0Lo) begin
      unit0CountLow_nxt = regWrData;
    end
    if (wrU0Hi) begin
      unit0CountHigh_nxt = regWrData;
    end
  end

  // unit 1 next count
  always_comb begin
    unit1CountLow_nxt  = unit1CountLow_r;
    unit1CountHigh_nxt = unit1CountHigh_r;
    if (unit1Inc) begin
      unit1CountLow_nxt  = unit1Step.lo;
      unit1CountHigh_nxt = unit1Step.hi;
    end
    if (wrU1Lo) begin
      unit1CountLow_nxt = regWrData;
    end
    if (wrU1Hi) begin
      unit1CountHigh_nxt = regWrData;
    end
  end

  // count registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      unit0CountLow_r  <= RST_BYTE;
      unit0CountHigh_r <= RST_BYTE;
      unit1CountLow_r  <= RST_BYTE;
      unit1CountHigh_r <= RST_BYTE;
    end else if (clkEn) begin
      unit0CountLow_r  <= unit0CountLow_nxt;
      unit0CountHigh_r <= unit0CountHigh_nxt;
      unit1CountLow_r  <= unit1CountLow_nxt;
      unit1CountHigh_r <= unit1CountHigh_nxt;
    end
  end

  // overflow events; in split mode unit 1 no longer owns its flag
  always_comb begin
    unit0OvfSet = unit0Inc && unit0Step.ovf;
    if (unit0Split) begin
      unit1OvfSet = unit0HiInc && (unit0CountHigh_r == 8'hff);
    end else begin
      unit1OvfSet = unit1Inc && unit1Step.ovf;
    end
  end

  // overflow flags: a set in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      unit0OverflowFlag <= 1'b0;
      unit1OverflowFlag <= 1'b0;
    end else if (clkEn) begin
      if (unit0OvfSet) begin
        unit0OverflowFlag <= 1'b1;
      end else if (unit0VectorAck) begin
        unit0OverflowFlag <= 1'b0;
      end else if (wrCtrl) begin
        unit0OverflowFlag <= regWrData[CTRL_U0_OVF];
      end
      if (unit1OvfSet) begin
        unit1OverflowFlag <= 1'b1;
      end else if (unit1VectorAck) begin
        unit1OverflowFlag <= 1'b0;
      end else if (wrCtrl) begin
        unit1OverflowFlag <= regWrData[CTRL_U1_OVF];
      end
    end
  end

  // read data stand for one cycle only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= RST_BYTE;
    end else if (clkEn) begin
      regRdData <= RST_BYTE;
      if (regRd) begin
        case (regAddr)
          ADDR_MODE: regRdData <= modeReg_r;
          ADDR_CTRL: begin
            regRdData <= RST_BYTE;
            regRdData[CTRL_U0_RUN] <= unit0Run_r;
            regRdData[CTRL_U0_OVF] <= unit0OverflowFlag;
            regRdData[CTRL_U1_RUN] <= unit1Run_r;
            regRdData[CTRL_U1_OVF] <= unit1OverflowFlag;
          end
          ADDR_RATE: regRdData <= rateReg_r;
          ADDR_U0LO: regRdData <= unit0CountLow_r;
          ADDR_U0HI: regRdData <= unit0CountHigh_r;
          ADDR_U1LO: regRdData <= unit1CountLow_r;
          ADDR_U1HI: regRdData <= unit1CountHigh_r;
          default:   regRdData <= RST_BYTE;
        endcase
      end
    end
  end

endmodule

// ### test/dtc_dual_timer_monitor.sv
// Purpose: port-level checks on the dual timer/counter
// Assumes: prescaler leaves reset at 0 and steps with clkEn, wrapping after 11
// Notes:   flags are judged against a mirror of the machine-cycle phase
`timescale 1ns/10ps
module dtc_dual_timer_monitor (
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               arst_n,
  input wire logic               clkEn,
  // register port
  input wire logic [2:0]         regAddr,
  input wire logic [7:0]         regWrData,
  input wire logic               regWr,
  input wire logic               regRd,
  input wire logic [7:0]         regRdData,
  // pins and interrupt side
  input wire dtc_pkg::dtc_pins_s pinsIn,
  input wire logic               unit0VectorAck,
  input wire logic               unit1VectorAck,
  input wire logic               unit0OverflowFlag,
  input wire logic               unit1OverflowFlag
);
  import dtc_pkg::*;
  logic [3:0] pre_r;
  logic       wrCtrl;
  assign wrCtrl = clkEn && regWr && (regAddr == ADDR_CTRL);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) pre_r <= 4'h0;
    else if (clkEn) pre_r <= (pre_r == PRE_LAST) ? 4'h0 : pre_r + 4'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_read_idle_zero: assert property (clkEn && !regRd |=> regRdData == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_read: assert property (clkEn && regRd && regAddr == 3'h7 |=> regRdData == 8'h00)
    else $error("unmapped index read non-zero");
  a_ctrl_read_flags: assert property (clkEn && regRd && regAddr == ADDR_CTRL |=>
    regRdData[3:0] == 4'h0 && regRdData[5] == $past(unit0OverflowFlag)
    && regRdData[7] == $past(unit1OverflowFlag)) else $error("control read mismatch");
  a_flag0_rise_c3: assert property ($rose(unit0OverflowFlag) && !$past(wrCtrl)
    |-> $past(pre_r[1:0]) == PHASE_C3) else $error("unit 0 flag set off phase");
  a_flag1_rise_c3: assert property ($rose(unit1OverflowFlag) && !$past(wrCtrl)
    |-> $past(pre_r[1:0]) == PHASE_C3) else $error("unit 1 flag set off phase");
  a_ack0_clears: assert property (clkEn && unit0VectorAck && pre_r[1:0] != PHASE_C3
    |=> !unit0OverflowFlag) else $error("unit 0 ack did not clear flag");
  a_ack1_clears: assert property (clkEn && unit1VectorAck && pre_r[1:0] != PHASE_C3
    |=> !unit1OverflowFlag) else $error("unit 1 ack did not clear flag");
  a_flag0_fall_cause: assert property ($fell(unit0OverflowFlag)
    |-> $past(unit0VectorAck) || $past(wrCtrl)) else $error("unit 0 flag fell uncaused");
  a_flag1_fall_cause: assert property ($fell(unit1OverflowFlag)
    |-> $past(unit1VectorAck) || $past(wrCtrl)) else $error("unit 1 flag fell uncaused");
endmodule
bind dtc_dual_timer dtc_dual_timer_monitor i_mon (.sys_clk(sys_clk), .arst_n(arst_n),
  .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .pinsIn(pinsIn), .unit0VectorAck(unit0VectorAck),
  .unit1VectorAck(unit1VectorAck), .unit0OverflowFlag(unit0OverflowFlag),
  .unit1OverflowFlag(unit1OverflowFlag));

// ### test/dtc_pin_model.sv
// Purpose: drives the external count and gate pins
// Assumes: bench pulses go for one cycle and waits while busy
// Notes:   count pins rest high; each level held 16 clocks
`timescale 1ns/10ps
module dtc_pin_model (
  // clock
  input wire logic         sys_clk,
  // command from bench
  input wire logic         go,
  input wire logic         unitSel,
  input wire logic [7:0]   nEdges,
  input wire logic [1:0]   gateLvl,
  // pins toward the timer, busy back to the bench
  output dtc_pkg::dtc_pins_s pins,
  output logic             busy
);
  import dtc_pkg::*;
  logic cnt0;
  logic cnt1;
  assign pins = {cnt0, cnt1, gateLvl[0], gateLvl[1]};
  // 32-clock edge period stays slower than one edge per 8 clocks
  initial begin
    cnt0 = 1'b1;
    cnt1 = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge sys_clk);
      if (go) begin
        busy <= 1'b1;
        for (int i = 0; i < nEdges; i++) begin
          repeat (16) @(posedge sys_clk);
          if (unitSel) cnt1 <= 1'b0;
          else cnt0 <= 1'b0;
          repeat (16) @(posedge sys_clk);
          cnt0 <= 1'b1;
          cnt1 <= 1'b1;
        end
        repeat (16) @(posedge sys_clk);
        busy <= 1'b0;
      end
    end
  end
endmodule

// ### test/test_dual_timer_counter.sv
// Purpose: self-checking bench for the dual timer/counter
// Assumes: 100 ns clock, pin model on the count and gate pins
// Notes:   overflow periods are timed between two flag rises
`timescale 1ns/10ps
module test_dual_timer_counter;
  import dtc_pkg::*;
  logic       sys_clk, arst_n, clkEn, regWr, regRd, u0Ack, u1Ack, go, unitSel, f0, f1, busy;
  logic [2:0] regAddr;
  logic [7:0] regWrData, regRdData, nEdges, rv, x, lo, hi;
  logic [1:0] gateLvl;
  dtc_pins_s  pins;
  int         miscompares, n_checks, t0;
  dtc_dual_timer i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .pinsIn(pins),
    .unit0VectorAck(u0Ack), .unit1VectorAck(u1Ack), .unit0OverflowFlag(f0),
    .unit1OverflowFlag(f1));
  dtc_pin_model i_pins (.sys_clk(sys_clk), .go(go), .unitSel(unitSel), .nEdges(nEdges),
    .gateLvl(gateLvl), .pins(pins), .busy(busy));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a; regWrData <= d; regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a; regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  task waitFlag(input int u, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge sys_clk);
      #1;
      if ((u == 0 ? f0 : f1) === 1'b1) break;
    end
    if (i == lim) begin
      miscompares++;
      conclude();
    end
  endtask
  task ack(input int u);
    @(posedge sys_clk);
    if (u == 0) u0Ack <= 1'b1;
    else u1Ack <= 1'b1;
    @(posedge sys_clk);
    u0Ack <= 1'b0; u1Ack <= 1'b0;
  endtask
  task pulses(input logic u, input logic [7:0] n);
    int i;
    @(posedge sys_clk);
    go <= 1'b1; unitSel <= u; nEdges <= n;
    @(posedge sys_clk);
    go <= 1'b0;
    for (i = 0; i < 400; i++) begin
      @(posedge sys_clk);
      #1;
      if (busy === 1'b0) break;
    end
    if (i == 400) begin
      miscompares++;
      conclude();
    end
  endtask
  function int period(input logic [7:0] reload, input logic fast);
    return (256 - int'(reload)) * (fast ? 6 : 12);
  endfunction
  initial begin
    miscompares = 0; n_checks = 0; arst_n = 1'b0; clkEn = 1'b1; regWr = 1'b0; regRd = 1'b0;
    regAddr = 3'h0; regWrData = 8'h00; u0Ack = 1'b0; u1Ack = 1'b0; go = 1'b0;
    unitSel = 1'b0; nEdges = 8'h00; gateLvl = 2'h3;
    void'($urandom(32'hc52c));
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), rv);
      chk(rv, 8'h00);
    end
    for (int a = 2; a < 7; a++) begin
      x = 8'($urandom);
      wr(3'(a), x);
      rd(3'(a), rv);
      chk(rv, x);
    end
    wr(3'h7, 8'hff);
    rd(3'h7, rv);
    chk(rv, 8'h00);
    @(posedge sys_clk);
    clkEn <= 1'b0;
    wr(ADDR_U1HI, ~x);
    clkEn <= 1'b1;
    rd(ADDR_U1HI, rv);
    chk(rv, x);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      lo = (k[1]) ? ADDR_U1LO : ADDR_U0LO;
      hi = (k[1]) ? ADDR_U1HI : ADDR_U0HI;
      // fast ticks alternate four and eight clocks apart: keep the tick count even
      rv = (8'hf8 + 8'($urandom_range(6))) & {7'h7f, ~k[0]};
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_RATE, {6'h00, k[0] & k[1], k[0] & ~k[1]});
      wr(hi[2:0], rv);
      wr(lo[2:0], rv);
      wr(ADDR_MODE, k[1] ? 8'h20 : 8'h02);
      wr(ADDR_CTRL, k[1] ? 8'h40 : 8'h10);
      waitFlag(k[1], 400);
      t0 = $time;
      ack(k[1]);
      waitFlag(k[1], 400);
      chk(8'(($time - t0) / 100), 8'(period(rv, k[0])));
      rd(hi[2:0], x);
      chk(x, rv);
    end
    $display("test reload periods done");
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_RATE, 8'h00);
      wr(ADDR_U0HI, 8'hff);
      wr(ADDR_U0LO, m ? 8'hff : 8'hbf);
      wr(ADDR_MODE, 8'(m));
      wr(ADDR_CTRL, 8'h10);
      waitFlag(0, 40);
      rd(ADDR_U0LO, rv);
      chk(rv, m ? 8'h00 : 8'ha0);
      rd(ADDR_U0HI, rv);
      chk(rv, 8'h00);
    end
    $display("test rollover done");
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_U1LO, 8'ha5);
    wr(ADDR_U0LO, 8'h3c);
    wr(ADDR_U0HI, 8'hfe);
    wr(ADDR_MODE, 8'h33);
    wr(ADDR_CTRL, 8'h40);
    waitFlag(1, 60);
    rd(ADDR_U1LO, rv);
    chk(rv, 8'ha5);
    rd(ADDR_U0LO, rv);
    chk(rv, 8'h3c);
    chk({7'h00, f0}, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    #1 chk({7'h00, f1}, 8'h00);
    wr(ADDR_MODE, 8'h13);
    repeat (23) @(posedge sys_clk);
    rd(ADDR_U1LO, rv);
    chk(rv, 8'ha7);
    $display("test split mode done");
    for (int u = 0; u < 2; u++) begin
      lo = u ? ADDR_U1LO : ADDR_U0LO;
      nEdges = 8'h00;
      x = 8'h01 + 8'($urandom_range(5));
      wr(ADDR_CTRL, 8'h00);
      wr(lo[2:0], 8'h00);
      wr(u ? ADDR_U1HI : ADDR_U0HI, 8'h00);
      wr(ADDR_MODE, u ? 8'h50 : 8'h05);
      wr(ADDR_CTRL, u ? 8'h40 : 8'h10);
      pulses(u[0], x);
      rd(lo[2:0], rv);
      chk(rv, x);
      gateLvl <= 2'h0;
      wr(ADDR_MODE, u ? 8'hd0 : 8'h0d);
      pulses(u[0], 8'h03);
      rd(lo[2:0], rv);
      chk(rv, x);
      gateLvl <= 2'h3;
      pulses(u[0], 8'h02);
      rd(lo[2:0], rv);
      chk(rv, x + 8'h02);
    end
    $display("test edge counting done");
    conclude();
  end
endmodule
